/* File: test_video_deinterlacer_stream_core.sv */
// test_video_deinterlacer_stream_core.sv: self-checking bench of vdi_core
// assumes vdi_mem_model on the memory port; bench is the axi-lite master
`timescale 1ns/1ps
`default_nettype none
module test_video_deinterlacer_stream_core;
  import vdi_pkg::*;
  logic mclk = 0, rst = 1, ce = 0, active_video_in = 0, hblank_in = 1;
  logic vblank_in = 0, active_chroma_in = 0, field_parity_input = 0;
  logic [PIX_W-1:0] vid_data_in = 0, vid_data_out, m_axis_tdata;
  logic hblank_out, vblank_out, active_video_out, active_chroma_out, en_out;
  logic [2:0] m_axis_tkeep, m_axis_tstrb;
  logic m_axis_tvalid, m_axis_tready = 0, m_axis_tlast, fsync_out, stall = 0;
  logic mem_cmd_reset, mem_cmd_full_flag, mem_cmd_write_strobe, mem_rd_reset;
  logic mem_wr_nearly_full_flag, mem_wr_full_flag, mem_wr_strobe;
  logic mem_wr_fifo_reset, mem_wr_fifo_flush, mem_wr_burst_end;
  logic mem_rd_strobe, mem_rd_burst_end, mem_rd_empty_flag, cpu_interrupt_line;
  logic [31:0] mem_cmd_word, mem_wr_data, mem_rd_data, s_axi_rdata, rd, b0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int num_errors = 0, samples_checked = 0, got = 0, nl = 0, nf = 0, nb = 0;
  int seed = 32'hf12199e8;
  bit bypass = 0, hold = 0;
  logic [PIX_W-1:0] exp_q[$];
  vdi_core i_dut (.*);
  vdi_mem_model i_mem (.mclk(mclk), .stall(stall), .wr_stb(mem_wr_strobe),
    .wr_data(mem_wr_data), .rd_stb(mem_rd_strobe),
    .cmd_full(mem_cmd_full_flag), .wr_full(mem_wr_full_flag),
    .wr_nfull(mem_wr_nearly_full_flag), .rd_empty(mem_rd_empty_flag),
    .rd_data(mem_rd_data));
  always #4 mclk = ~mclk;
  task automatic finish_test;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    samples_checked++;
    if (a !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, a, e);
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    bit b;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    b = 0;
    while (!b) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      b = s_axi_bready & s_axi_bvalid;
    end
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [31:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge mclk);
    {r, rd} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 0;
  endtask
  // one field: a pixel is held two cycles so ce catches it once
  task automatic field(input int lines, input int px);
    logic [31:0] p;
    {vblank_in, field_parity_input} <= 2'h2;
    repeat (8) @(posedge mclk);
    vblank_in <= 0;
    repeat (lines) begin
      hblank_in <= 0;
      repeat (px) begin
        p = $random(seed);
        {vid_data_in, active_video_in} <= {p[PIX_W-1:0], 1'b1};
        if (bypass) exp_q.push_back(p[PIX_W-1:0]);
        repeat (2) @(posedge mclk);
      end
      {active_video_in, hblank_in} <= 2'h1;
      repeat (16) @(posedge mclk);
    end
  endtask
  task automatic settle(input int n);
    for (int i = 0; i < 4000 && got != n; i++) @(posedge mclk);
    chk(got, n);
  endtask
  // random consumer and memory stalls; every taken pixel is scored
  always @(posedge mclk) begin
    ce <= ~ce;
    m_axis_tready <= !hold && ($random(seed) & 3) != 0;
    stall <= ($random(seed) & 3) == 0;
    nf <= nf + fsync_out;
    nb <= nb + mem_wr_burst_end + mem_rd_burst_end;
    if (m_axis_tvalid & m_axis_tready) begin
      got = got + 1;
      nl = nl + m_axis_tlast;
      chk({m_axis_tkeep, m_axis_tstrb}, 6'h3f);
      if (bypass) chk(m_axis_tdata, exp_q.pop_front());
    end
    if (mem_cmd_write_strobe) chk(mem_cmd_word, b0);
    if (mem_wr_strobe) chk(mem_wr_data[31:PIX_W], 0);
    if (mem_wr_strobe & mem_wr_full_flag) chk(1, 0);
    if (mem_rd_strobe & mem_rd_empty_flag) chk(1, 0);
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 0;
    axr(OFS_CTRL);
    chk(rd, CTRL_RESET);
    axr(32'h40);
    chk({r, rd[1:0]}, {RESP_SLVERR, 2'h0});
    b0 = $random(seed) & 32'hffff_fff0;
    axw(OFS_BASE0, b0);
    axw(OFS_BASE1, b0);
    axw(OFS_BASE2, b0);
    axr(OFS_BASE2);
    chk(rd, b0);
    bypass = 1;
    axw(OFS_CTRL, 0);
    field(2, 16);
    settle(32);
    chk(nl, 2);
    bypass = 0;
    for (int q = 0; q < 4; q++) begin
      axw(OFS_CTRL, {q[1:0], 1'b1});
      got = 0;
      field(3, 16);
      settle(96);
    end
    chk(nf >= 4, 1);
    chk(nb, 12);
    hold = 1;
    field(10, 512);
    chk(cpu_interrupt_line, 1);
    axr(OFS_STATUS);
    chk(rd[STAT_RESYNC:STAT_OVF], 2'h3);
    axw(OFS_STATUS, 1);
    hold = 0;
    axr(OFS_STATUS);
    chk(rd[STAT_OVF], 0);
    field(1, 16);
    axr(OFS_STATUS);
    chk(rd[STAT_RESYNC], 0);
    finish_test;
  end
  initial begin
    #200000;
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire

/* File: vdi_core.sv */
// vdi_core.sv: deinterlacer stream core with register slave and memory port
// assumes video and memory side share mclk; ce throttles the video work
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - four quality levels, fixed or run-time selected
// - motion option drives memory port, else it stays idle
// - diagonal option uses on-chip resources only
// - first output about four pixels after input
// - two output pixels per input pixel
// - one-line input holding buffer
// - 1000-pixel output holding buffer
// - overflow raises interrupt, flushes, resyncs
// - drop all input while resynchronising
// - exactly one memory port style built
// - software-set field buffer addresses used
// - strobe input; output strobe or stream
// - clock enable low holds processing
// - memory port on memory clock
// - frame sync pulse per output frame
// - strobe output drives blanking, strobes, enable
// - stream output valid, ready, last, keep
// - command words with strobe, honour full
// - write data with strobe, flags, burst end
// - interrupt is active-high level
module vdi_core import vdi_pkg::*; #(
  parameter bit         motion_option_param   = 1'b1,
  parameter bit         diagonal_option_param = 1'b1,
  parameter bit         QUALITY_RUNTIME       = 1'b1,
  parameter logic [1:0] QUALITY_FIXED         = Q_MOTION_DIAG,
  parameter bit         OUT_AXIS              = 1'b1
)(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [PIX_W-1:0] vid_data_in,
  input  wire logic             hblank_in,
  input  wire logic             vblank_in,
  input  wire logic             active_video_in,
  input  wire logic             active_chroma_in,
  input  wire logic             field_parity_input,
  output logic [PIX_W-1:0]      vid_data_out,
  output logic                  hblank_out,
  output logic                  vblank_out,
  output logic                  active_video_out,
  output logic                  active_chroma_out,
  output logic                  en_out,
  output logic [PIX_W-1:0]      m_axis_tdata,
  output logic [2:0]            m_axis_tkeep,
  output logic [2:0]            m_axis_tstrb,
  output logic                  m_axis_tvalid,
  input  wire logic             m_axis_tready,
  output logic                  m_axis_tlast,
  output logic                  fsync_out,
  output logic                  mem_cmd_reset,
  input  wire logic             mem_cmd_full_flag,
  output logic                  mem_cmd_write_strobe,
  output logic [31:0]           mem_cmd_word,
  input  wire logic             mem_wr_nearly_full_flag,
  input  wire logic             mem_wr_full_flag,
  output logic [31:0]           mem_wr_data,
  output logic                  mem_wr_strobe,
  output logic                  mem_wr_fifo_reset,
  output logic                  mem_wr_fifo_flush,
  output logic                  mem_wr_burst_end,
  output logic                  mem_rd_reset,
  output logic                  mem_rd_strobe,
  input  wire logic [31:0]      mem_rd_data,
  output logic                  mem_rd_burst_end,
  input  wire logic             mem_rd_empty_flag,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic                  cpu_interrupt_line
);
  typedef enum logic [1:0] {
    ENG_ORIG   = 2'b01,
    ENG_INTERP = 2'b10
  } vdi_eng_t;

  typedef struct packed {
    logic              aw_ok;
    logic [31:0]       aw_addr;
    logic              w_ok;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [31:0]       ctrl;
    logic [31:0]       base0;
    logic [31:0]       base1;
    logic [31:0]       base2;
    logic              ovf;
    logic              hold_v;
    logic [ITEM_W-1:0] hold;
    logic              act_d;
    logic              vbl_d;
    logic              sof_pend;
    logic              resync;
    vdi_eng_t          eng;
    logic [X_W-1:0]    x;
    logic [X_W-1:0]    len;
    logic              bank;
    logic              cmd_sent;
    logic [1:0]        buf_idx;
    logic              ov_v;
    logic [ITEM_W-1:0] ov;
    logic              flush;
  } vdi_state_t;

  vdi_state_t        st_reg;
  vdi_state_t        st_next;
  logic [PIX_W:0]    lmem [2][LINE_MAX];
  logic              in_push;
  logic [ITEM_W-1:0] in_item;
  logic              in_rdy;
  logic              in_v;
  logic [ITEM_W-1:0] in_head;
  logic              in_pop;
  logic              out_push;
  logic [ITEM_W-1:0] out_item;
  logic              out_rdy;
  logic              out_v;
  logic [ITEM_W-1:0] out_head;
  logic              out_pop;
  logic              take;
  logic              ovf_evt;
  logic              lw_en;
  logic [1:0]        q;
  logic              motion_on;
  logic              diag_on;
  logic              bypass;
  logic              mem_on;
  logic              last_x;
  logic [XA_W-1:0]   xa;
  logic [XA_W-1:0]   xm;
  logic [XA_W-1:0]   xp;
  logic [PIX_W-1:0]  vert;
  logic [PIX_W-1:0]  ipix;
  logic [31:0]       rd_val;
  logic              rd_err;

  // per-channel mean, shared by every interpolation path
  function automatic logic [PIX_W-1:0] avg(input logic [PIX_W-1:0] a,
                                           input logic [PIX_W-1:0] b);
    logic [CH_W:0] s;
    avg = '0;
    for (int i = 0; i < NCH; i++) begin
      s = {1'b0, a[i*CH_W +: CH_W]} + {1'b0, b[i*CH_W +: CH_W]};
      avg[i*CH_W +: CH_W] = s[CH_W:1];
    end
  endfunction

  // register write honouring the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // one line of input holding, one thousand pixels of output holding
  vdi_fifo #(.W(ITEM_W), .D(IN_DEPTH)) u_in_buf (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (st_reg.flush),
    .in_valid  (in_push),
    .in_ready  (in_rdy),
    .in_data   (in_item),
    .out_valid (in_v),
    .out_ready (in_pop),
    .out_data  (in_head)
  );
  vdi_fifo #(.W(ITEM_W), .D(OUT_DEPTH)) u_out_buf (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (st_reg.flush),
    .in_valid  (out_push),
    .in_ready  (out_rdy),
    .in_data   (out_item),
    .out_valid (out_v),
    .out_ready (out_pop),
    .out_data  (out_head)
  );

  // quality follows the build choice or the control register
  assign q = QUALITY_RUNTIME ? st_reg.ctrl[CTRL_QHI:CTRL_QLO] : QUALITY_FIXED;
  assign motion_on = motion_option_param & q[1];
  assign diag_on   = diagonal_option_param & q[0];
  assign bypass    = ~st_reg.ctrl[CTRL_EN];
  assign mem_on    = motion_on & ~bypass;
  assign last_x    = st_reg.x == st_reg.len - 1'b1;
  assign xa        = st_reg.x[XA_W-1:0];
  assign xm        = (xa == '0) ? xa : xa - 1'b1;
  assign xp        = last_x ? xa : xa + 1'b1;

  // interpolated line: vertical mean, diagonal blend, stored field blend
  always_comb begin
    vert = avg(lmem[st_reg.bank][xa][PIX_W-1:0],
               lmem[~st_reg.bank][xa][PIX_W-1:0]);
    ipix = vert;
    if (diag_on) begin
      ipix = avg(vert, avg(lmem[st_reg.bank][xm][PIX_W-1:0],
                           lmem[~st_reg.bank][xp][PIX_W-1:0]));
    end
    if (motion_on) ipix = avg(ipix, mem_rd_data[PIX_W-1:0]);
  end

  // register read decode; unmapped offsets answer with an error
  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    case (s_axi_araddr)
      OFS_CTRL:   rd_val = st_reg.ctrl;
      OFS_STATUS: begin
        rd_val[STAT_OVF]    = st_reg.ovf;
        rd_val[STAT_RESYNC] = st_reg.resync;
        rd_val[STAT_EMPTY]  = ~in_v;
      end
      OFS_BASE0:  rd_val = st_reg.base0;
      OFS_BASE1:  rd_val = st_reg.base1;
      OFS_BASE2:  rd_val = st_reg.base2;
      default:    rd_err = 1'b1;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.flush = 1'b0;
    in_push = 1'b0;
    in_item = st_reg.hold;
    in_pop = 1'b0;
    out_push = 1'b0;
    out_item = in_head;
    lw_en = 1'b0;
    mem_cmd_write_strobe = 1'b0;
    mem_wr_strobe = 1'b0;
    mem_wr_burst_end = 1'b0;
    mem_rd_strobe = 1'b0;
    mem_rd_burst_end = 1'b0;
    // bus slave: address and data in either order, answer after both
    s_axi_awready = ~st_reg.aw_ok & ~st_reg.bvalid;
    s_axi_wready  = ~st_reg.w_ok & ~st_reg.bvalid;
    s_axi_arready = ~st_reg.rvalid;
    if (s_axi_awvalid & s_axi_awready) begin
      st_next.aw_ok = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      st_next.w_ok = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid & s_axi_bready) st_next.bvalid = 1'b0;
    if (st_reg.aw_ok & st_reg.w_ok) begin
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.aw_addr)
        OFS_CTRL:   st_next.ctrl = merge(st_reg.ctrl, st_reg.w_data,
                                         st_reg.w_strb);
        OFS_STATUS: begin
          if (st_reg.w_strb[0] & st_reg.w_data[STAT_OVF]) st_next.ovf = 1'b0;
        end
        OFS_BASE0:  st_next.base0 = merge(st_reg.base0, st_reg.w_data,
                                          st_reg.w_strb);
        OFS_BASE1:  st_next.base1 = merge(st_reg.base1, st_reg.w_data,
                                          st_reg.w_strb);
        OFS_BASE2:  st_next.base2 = merge(st_reg.base2, st_reg.w_data,
                                          st_reg.w_strb);
        default:    st_next.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid & s_axi_rready) st_next.rvalid = 1'b0;
    if (s_axi_arvalid & s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_val;
      st_next.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    // video work only advances on ce, and sits out the flush cycle so the
    // engine never pops a head that the flush is about to discard
    if (ce & ~st_reg.flush) begin
      st_next.act_d = active_video_in;
      st_next.vbl_d = vblank_in;
      if (vblank_in & ~st_reg.vbl_d) st_next.sof_pend = 1'b1;
      // one pixel is held back so the last of a line can carry its mark
      if (active_video_in & ~st_reg.resync) begin
        in_push = st_reg.hold_v;
        in_item[IT_EOL] = 1'b0;
        st_next.hold_v = 1'b1;
        st_next.hold = {active_chroma_in, st_reg.sof_pend, 1'b0,
                        vid_data_in};
        st_next.sof_pend = 1'b0;
      end else if (st_reg.act_d & st_reg.hold_v & ~st_reg.resync) begin
        in_push = 1'b1;
        in_item[IT_EOL] = 1'b1;
        st_next.hold_v = 1'b0;
      end
      // frame boundary: vertical blanking opens on the first field
      if (st_reg.resync & vblank_in & ~st_reg.vbl_d & ~field_parity_input) begin
        st_next.resync = 1'b0;
      end
      case (st_reg.eng)
        ENG_ORIG: begin
          if (in_v & in_head[IT_SOF] & mem_on & ~st_reg.cmd_sent) begin
            if (~mem_cmd_full_flag) begin
              mem_cmd_write_strobe = 1'b1;
              st_next.cmd_sent = 1'b1;
              st_next.buf_idx = (st_reg.buf_idx == 2'h2) ? 2'h0
                                : st_reg.buf_idx + 2'h1;
            end
          end else if (in_v & out_rdy & (~mem_on | (~mem_wr_full_flag &
                       ~(st_reg.x == '0 & mem_wr_nearly_full_flag)))) begin
            // original line goes out as it arrives and is kept
            in_pop = 1'b1;
            out_push = 1'b1;
            lw_en = 1'b1;
            mem_wr_strobe = mem_on;
            mem_wr_burst_end = mem_on & in_head[IT_EOL];
            st_next.cmd_sent = st_reg.cmd_sent & ~in_head[IT_SOF];
            st_next.x = st_reg.x + 1'b1;
            if (in_head[IT_EOL]) begin
              st_next.len = st_reg.x + 1'b1;
              st_next.x = '0;
              if (~bypass) st_next.eng = ENG_INTERP;
            end
          end
        end
        ENG_INTERP: begin
          // the missing line is rebuilt from stored lines
          if (out_rdy & (~motion_on | ~mem_rd_empty_flag)) begin
            out_push = 1'b1;
            out_item = {lmem[st_reg.bank][xa][PIX_W], 1'b0, last_x, ipix};
            mem_rd_strobe = motion_on;
            mem_rd_burst_end = motion_on & last_x;
            st_next.x = st_reg.x + 1'b1;
            if (last_x) begin
              st_next.x = '0;
              st_next.bank = ~st_reg.bank;
              st_next.eng = ENG_ORIG;
            end
          end
        end
        default: st_next.eng = ENG_ORIG;
      endcase
    end
    // input overflow: flag, flush both buffers and the memory port, wait for a frame boundary
    ovf_evt = in_push & ~in_rdy;
    if (ovf_evt) begin
      st_next.ovf = 1'b1;
      st_next.resync = 1'b1;
      st_next.hold_v = 1'b0;
      st_next.flush = 1'b1;
      st_next.eng = ENG_ORIG;
      st_next.x = '0;
      st_next.cmd_sent = 1'b0;
    end
    // output stage: one register so data and valid come from flops; en_out and fsync_out follow take
    take = st_reg.ov_v & (OUT_AXIS ? m_axis_tready : ce);
    out_pop = ce & out_v & (~st_reg.ov_v | take) & ~st_reg.flush;
    if (take) st_next.ov_v = 1'b0;
    if (out_pop) begin
      st_next.ov_v = 1'b1;
      st_next.ov = out_head;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.base0 <= BASE_RESET;
      st_reg.base1 <= BASE_RESET;
      st_reg.base2 <= BASE_RESET;
      st_reg.eng <= ENG_ORIG;
    end else begin
      st_reg <= st_next;
    end
  end

  // line store lives outside the state record, only written on a pop
  always_ff @(posedge mclk) begin
    if (lw_en) lmem[st_reg.bank][xa] <= {in_head[IT_CHR], in_head[PIX_W-1:0]};
  end

  // memory port is always built; without the motion option its strobes and resets stay low
  assign mem_cmd_word = (st_reg.buf_idx == 2'h0) ? st_reg.base0 :
                        (st_reg.buf_idx == 2'h1) ? st_reg.base1 :
                        st_reg.base2;
  assign mem_wr_data       = {{(32 - PIX_W){1'b0}}, in_head[PIX_W-1:0]};
  assign mem_cmd_reset     = motion_option_param & st_reg.flush;
  assign mem_wr_fifo_reset = motion_option_param & st_reg.flush;
  assign mem_wr_fifo_flush = motion_option_param & st_reg.flush;
  assign mem_rd_reset      = motion_option_param & st_reg.flush;

  // strobe-style output
  assign vid_data_out      = OUT_AXIS ? '0 : st_reg.ov[PIX_W-1:0];
  assign active_video_out  = ~OUT_AXIS & st_reg.ov_v;
  assign active_chroma_out = ~OUT_AXIS & st_reg.ov_v & st_reg.ov[IT_CHR];
  assign en_out            = ~OUT_AXIS & take;
  assign hblank_out        = ~OUT_AXIS & ~st_reg.ov_v;
  assign vblank_out        = ~OUT_AXIS & ~st_reg.ov_v & ~out_v;
  // stream output; valid stays up until ready, nothing else drops it
  assign m_axis_tvalid = OUT_AXIS & st_reg.ov_v;
  assign m_axis_tdata  = OUT_AXIS ? st_reg.ov[PIX_W-1:0] : '0;
  assign m_axis_tlast  = OUT_AXIS & st_reg.ov[IT_EOL];
  assign m_axis_tkeep  = OUT_AXIS ? 3'h7 : 3'h0;
  assign m_axis_tstrb  = OUT_AXIS ? 3'h7 : 3'h0;
  assign fsync_out     = take & st_reg.ov[IT_SOF];
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign cpu_interrupt_line = st_reg.ovf;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_cmd_full_hold: assert property (mem_cmd_write_strobe |->
    !mem_cmd_full_flag) else $error("command strobe while full");
  a_wr_full_hold: assert property (mem_wr_strobe |->
    !mem_wr_full_flag) else $error("write strobe while full");
  a_rd_empty_hold: assert property (mem_rd_strobe |->
    !mem_rd_empty_flag) else $error("read strobe while empty");
  a_axis_payload_hold: assert property (m_axis_tvalid && !m_axis_tready
    |=> m_axis_tvalid && $stable(m_axis_tdata) && $stable(m_axis_tlast))
    else $error("stream payload changed before ready");
  a_ovf_flush_resync: assert property (in_push && !in_rdy
    |=> st_reg.resync && st_reg.flush && cpu_interrupt_line ##1 !out_v)
    else $error("overflow did not flush and resync");
  a_resync_drop: assert property (st_reg.resync |-> !in_push)
    else $error("input accepted while resynchronising");
  a_ce_stall: assert property (!ce && !(in_push && !in_rdy)
    |=> $stable(st_reg.eng) && $stable(st_reg.x) && $stable(st_reg.hold_v))
    else $error("video state moved with ce low");
  a_motion_off_quiet: assert property (!motion_on |->
    !mem_wr_strobe && !mem_rd_strobe && !mem_cmd_write_strobe)
    else $error("memory port used without motion option");
  a_irq_sticky: assert property (cpu_interrupt_line &&
    !(st_reg.aw_ok && st_reg.w_ok) |=> cpu_interrupt_line)
    else $error("interrupt dropped without a clear");
endmodule
`default_nettype wire

/* File: vdi_fifo.sv */
// vdi_fifo.sv: shared constants and the holding buffer of the deinterlacer
// assumes one clock; flush empties the buffer in one cycle
`timescale 1ns/1ps
`default_nettype none
package vdi_pkg;
  localparam int CH_W     = 8;
  localparam int NCH      = 3;
  localparam int PIX_W    = CH_W * NCH;
  localparam int LINE_MAX = 2048;
  localparam int XA_W     = 11;
  localparam int X_W      = 12;
  localparam int IN_DEPTH  = LINE_MAX;
  localparam int OUT_DEPTH = 1000;
  // buffer item: {chroma, start of frame, end of line, pixel}
  localparam int ITEM_W   = PIX_W + 3;
  localparam int IT_EOL   = PIX_W;
  localparam int IT_SOF   = PIX_W + 1;
  localparam int IT_CHR   = PIX_W + 2;
  localparam logic [1:0] Q_FIELD       = 2'h0;
  localparam logic [1:0] Q_FIELD_DIAG  = 2'h1;
  localparam logic [1:0] Q_MOTION      = 2'h2;
  localparam logic [1:0] Q_MOTION_DIAG = 2'h3;
  localparam logic [31:0] OFS_CTRL   = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_BASE0  = 32'h0000_0008;
  localparam logic [31:0] OFS_BASE1  = 32'h0000_000c;
  localparam logic [31:0] OFS_BASE2  = 32'h0000_0010;
  localparam int CTRL_EN  = 0;
  localparam int CTRL_QLO = 1;
  localparam int CTRL_QHI = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam int STAT_OVF    = 0;
  localparam int STAT_RESYNC = 1;
  localparam int STAT_EMPTY  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

module vdi_fifo import vdi_pkg::*; #(
  parameter int W = ITEM_W,
  parameter int D = OUT_DEPTH
)(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } vdi_fifo_st_t;
  vdi_fifo_st_t st_reg;
  vdi_fifo_st_t st_next;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  // pointers wrap at the depth, which need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  // full and empty come straight from the occupancy count
  assign in_ready  = st_reg.cnt != CW'(D);
  assign out_valid = st_reg.cnt != '0;
  assign out_data  = mem[st_reg.rp];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  always_comb begin
    st_next = st_reg;
    if (flush) begin
      st_next = '0;
    end else begin
      if (push) st_next.wp = bump(st_reg.wp);
      if (pop) st_next.rp = bump(st_reg.rp);
      st_next.cnt = st_reg.cnt + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) st_reg <= '0;
    else st_reg <= st_next;
  end

  // storage needs no reset, the count guards every read
  always_ff @(posedge mclk) begin
    if (push) mem[st_reg.wp] <= in_data;
  end
endmodule
`default_nettype wire

/* File: vdi_mem_model.sv */
// vdi_mem_model.sv: frame-buffer memory controller seen by the core
// assumes the single-clock port; stall makes every flag busy
`timescale 1ns/1ps
`default_nettype none
module vdi_mem_model (
  input  wire logic        mclk,
  input  wire logic        stall,
  input  wire logic        wr_stb,
  input  wire logic [31:0] wr_data,
  input  wire logic        rd_stb,
  output logic             cmd_full,
  output logic             wr_full,
  output logic             wr_nfull,
  output logic             rd_empty,
  output logic [31:0]      rd_data
);
  logic [31:0] mem_q[$];
  logic [31:0] pat = 32'h5a5a_0f0f;
  // flags lag stall by a cycle; empty reads see a moving pattern
  always @(posedge mclk) begin
    cmd_full <= stall;
    wr_full  <= stall;
    wr_nfull <= stall;
    rd_empty <= stall;
    if (wr_stb)
      mem_q.push_back(wr_data);
    if (rd_stb && mem_q.size() > 0)
      void'(mem_q.pop_front());
    rd_data <= (mem_q.size() > 0) ? mem_q[0] : ~pat;
    pat <= pat + 32'h1;
  end
endmodule
`default_nettype wire
